//--- src/aml_core.sv
// accumulator mode, shift and flag logic with its register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
module aml_core #(
    parameter int ADDR_W = 8,
    parameter bit EARLY_STORE = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input aml_pkg::aml_instr_s instr,
    output logic [aml_pkg::ACC_W-1:0] acc_q,
    output logic [aml_pkg::ACC_W-1:0] product_reg_q,
    output logic store_valid_q,
    output logic [aml_pkg::DATA_W-1:0] store_data_q,
    output logic branch_valid_q,
    output logic branch_taken_q,
    output logic sign_ext_mode_bit_q,
    output logic saturate_mode_bit_q,
    output logic overflow_flag_q,
    output logic test_control_flag_q,
    output logic [1:0] product_shift_field_q,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int AW = aml_pkg::ACC_W;
    localparam int DW = aml_pkg::DATA_W;

    if (ADDR_W < aml_pkg::REG_SPAN_BITS || ADDR_W > 32) begin : g_chk
        $error("address width out of range");
    end

    logic [DW-1:0] mcand_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_do;
    aml_pkg::aml_reg_e wr_sel;
    aml_pkg::aml_reg_e rd_sel;
    logic [31:0] rd_word;
    logic [AW-1:0] acc_d;
    logic acc_we;
    logic [AW-1:0] prod_d;
    logic prod_we;
    logic ovf_ev;
    logic [AW-1:0] in_sh;
    logic [AW-1:0] prod_sh;
    logic [AW-1:0] store_word;
    logic [aml_pkg::STORE_SH_W-1:0] st_sh;
    logic [aml_pkg::SHIFT_W-1:0] bit_code;
    aml_pkg::aml_sum_s sum;
    logic go;

    // sign or zero extension of a data word
    function automatic logic [AW-1:0] ext16(input logic [DW-1:0] d,
                                            input logic sx);
        ext16 = sx ? {{(AW-DW){d[DW-1]}}, d} : {{(AW-DW){1'b0}}, d};
    endfunction : ext16

    // product scaling before accumulation or store
    function automatic logic [AW-1:0] pshift(input logic [AW-1:0] p,
                                             input logic [1:0] f);
        unique case (aml_pkg::aml_psh_e'(f))
            aml_pkg::PSH_NONE: pshift = p;
            aml_pkg::PSH_LEFT1: pshift = p << aml_pkg::PSH_L1;
            aml_pkg::PSH_LEFT4: pshift = p << aml_pkg::PSH_L4;
            aml_pkg::PSH_RIGHT6:
                pshift = AW'($signed(p) >>> aml_pkg::PSH_R6);
        endcase
    endfunction : pshift

    // add or subtract with overflow detect and optional saturation
    function automatic aml_pkg::aml_sum_s alu_sum(input logic [AW-1:0] a,
                                                  input logic [AW-1:0] b,
                                                  input logic sub,
                                                  input logic sat);
        logic [AW:0] s;
        aml_pkg::aml_sum_s r;
        s = sub ? {a[AW-1], a} - {b[AW-1], b}
                : {a[AW-1], a} + {b[AW-1], b};
        r.ovf = s[AW] ^ s[AW-1];
        if (r.ovf && sat) begin
            r.val = s[AW] ? aml_pkg::ACC_MIN : aml_pkg::ACC_MAX;
        end else begin
            r.val = s[AW-1:0];
        end
        return r;
    endfunction : alu_sum

    // register decode, low two address bits ignored
    function automatic aml_pkg::aml_reg_e reg_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'h0};
        if (w == ADDR_W'(aml_pkg::OFF_STATUS_ZERO)) begin
            reg_sel = aml_pkg::REG_STATUS_ZERO;
        end else if (w == ADDR_W'(aml_pkg::OFF_STATUS_ONE)) begin
            reg_sel = aml_pkg::REG_STATUS_ONE;
        end else if (w == ADDR_W'(aml_pkg::OFF_ACC)) begin
            reg_sel = aml_pkg::REG_ACC;
        end else if (w == ADDR_W'(aml_pkg::OFF_PRODUCT)) begin
            reg_sel = aml_pkg::REG_PRODUCT;
        end else if (w == ADDR_W'(aml_pkg::OFF_MCAND)) begin
            reg_sel = aml_pkg::REG_MCAND;
        end else begin
            reg_sel = aml_pkg::REG_NONE;
        end
    endfunction : reg_sel

    assign go = ce && instr.valid;
    assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_sel = reg_sel(awaddr_q);
    assign rd_sel = reg_sel(s_axi_araddr);

    // incoming operand path and store path
    always_comb begin
        unique case (instr.op)
            aml_pkg::OP_ACC_LOAD_VAR, aml_pkg::OP_ADD_VAR,
            aml_pkg::OP_SUB_VAR:
                in_sh = ext16(instr.data, sign_ext_mode_bit_q)
                        << mcand_q[aml_pkg::SHIFT_W-1:0];
            default:
                in_sh = ext16(instr.data, sign_ext_mode_bit_q)
                        << instr.arg;
        endcase
        prod_sh = pshift(product_reg_q, product_shift_field_q);
        st_sh = instr.arg[aml_pkg::STORE_SH_W-1:0];
        if (EARLY_STORE && st_sh != aml_pkg::EARLY_SH_A
                && st_sh != aml_pkg::EARLY_SH_B) begin
            st_sh = '0;
        end
        store_word = acc_q << st_sh;
        bit_code = (instr.op == aml_pkg::OP_BIT_TEST_VAR)
                   ? mcand_q[aml_pkg::SHIFT_W-1:0] : instr.arg;
    end

    // accumulator and product next values, one cycle per op
    always_comb begin
        acc_d = acc_q;
        acc_we = 1'b0;
        prod_d = product_reg_q;
        prod_we = 1'b0;
        ovf_ev = 1'b0;
        sum = alu_sum(acc_q, in_sh, 1'b0, saturate_mode_bit_q);
        unique case (instr.op)
            aml_pkg::OP_ACC_LOAD, aml_pkg::OP_ACC_LOAD_VAR: begin
                acc_d = in_sh;
                acc_we = 1'b1;
            end
            aml_pkg::OP_ADD, aml_pkg::OP_ADD_VAR,
            aml_pkg::OP_SUB, aml_pkg::OP_SUB_VAR: begin
                sum = alu_sum(acc_q, in_sh,
                              instr.op == aml_pkg::OP_SUB
                              || instr.op == aml_pkg::OP_SUB_VAR,
                              saturate_mode_bit_q);
                acc_d = sum.val;
                acc_we = 1'b1;
                ovf_ev = sum.ovf;
            end
            aml_pkg::OP_PROD_LOAD: begin
                acc_d = prod_sh;
                acc_we = 1'b1;
            end
            aml_pkg::OP_PROD_ADD, aml_pkg::OP_PROD_SUB,
            aml_pkg::OP_MULT_ACC, aml_pkg::OP_SQUARE_ACC: begin
                sum = alu_sum(acc_q, prod_sh,
                              instr.op == aml_pkg::OP_PROD_SUB,
                              saturate_mode_bit_q);
                acc_d = sum.val;
                acc_we = 1'b1;
                ovf_ev = sum.ovf;
            end
            aml_pkg::OP_ACC_SHL: begin
                acc_d = acc_q << 1;
                acc_we = 1'b1;
            end
            aml_pkg::OP_ACC_SHR: begin
                acc_d = sign_ext_mode_bit_q ? AW'($signed(acc_q) >>> 1)
                                            : acc_q >> 1;
                acc_we = 1'b1;
            end
            default: begin
            end
        endcase
        unique case (instr.op)
            aml_pkg::OP_MULT, aml_pkg::OP_MULT_ACC: begin
                prod_d = AW'($signed(instr.data) * $signed(mcand_q));
                prod_we = 1'b1;
            end
            aml_pkg::OP_SQUARE_ACC: begin
                prod_d = AW'($signed(instr.data) * $signed(instr.data));
                prod_we = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // accumulator
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_q <= '0;
        end else if (go && acc_we) begin
            acc_q <= acc_d;
        end
    end

    // product register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            product_reg_q <= '0;
        end else if (go && prod_we) begin
            product_reg_q <= prod_d;
        end
    end

    // multiplicand register, op load wins over bus write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mcand_q <= '0;
        end else if (ce) begin
            if (wr_do && wr_sel == aml_pkg::REG_MCAND) begin
                if (wstrb_q[0]) mcand_q[7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) mcand_q[DW-1:8] <= wdata_q[DW-1:8];
            end
            if (go && instr.op == aml_pkg::OP_MCAND_LOAD) begin
                mcand_q <= instr.data;
            end
        end
    end

    // mode bits and flags
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sign_ext_mode_bit_q <= aml_pkg::RST_SEXT;
            saturate_mode_bit_q <= aml_pkg::RST_SAT;
            product_shift_field_q <= aml_pkg::RST_PSH;
            overflow_flag_q <= 1'b0;
            test_control_flag_q <= 1'b0;
        end else if (ce) begin
            if (wr_do && wstrb_q[0]
                    && wr_sel == aml_pkg::REG_STATUS_ZERO) begin
                saturate_mode_bit_q <= wdata_q[aml_pkg::Z_SAT_BIT];
                overflow_flag_q <= wdata_q[aml_pkg::Z_OVF_BIT];
            end
            if (wr_do && wstrb_q[0]
                    && wr_sel == aml_pkg::REG_STATUS_ONE) begin
                sign_ext_mode_bit_q <= wdata_q[aml_pkg::O_SEXT_BIT];
                test_control_flag_q <= wdata_q[aml_pkg::O_TCF_BIT];
                product_shift_field_q <=
                    wdata_q[aml_pkg::O_PSH_HI:aml_pkg::O_PSH_LO];
            end
            if (go) begin
                unique case (instr.op)
                    aml_pkg::OP_SET_SIGN_EXT: sign_ext_mode_bit_q <= 1'b1;
                    aml_pkg::OP_CLR_SIGN_EXT: sign_ext_mode_bit_q <= 1'b0;
                    aml_pkg::OP_SET_SAT: saturate_mode_bit_q <= 1'b1;
                    aml_pkg::OP_CLR_SAT: saturate_mode_bit_q <= 1'b0;
                    aml_pkg::OP_SET_PROD_SHIFT:
                        product_shift_field_q <= instr.arg[1:0];
                    aml_pkg::OP_LOAD_STATUS: begin
                        saturate_mode_bit_q <=
                            instr.data[aml_pkg::Z_SAT_BIT];
                        overflow_flag_q <= instr.data[aml_pkg::Z_OVF_BIT];
                    end
                    aml_pkg::OP_LOAD_STATUS_ONE: begin
                        sign_ext_mode_bit_q <=
                            instr.data[aml_pkg::O_SEXT_BIT];
                        test_control_flag_q <=
                            instr.data[aml_pkg::O_TCF_BIT];
                        product_shift_field_q <=
                            instr.data[aml_pkg::O_PSH_HI:aml_pkg::O_PSH_LO];
                    end
                    aml_pkg::OP_BIT_TEST, aml_pkg::OP_BIT_TEST_VAR:
                        test_control_flag_q <=
                            instr.data[aml_pkg::BIT_CODE_TOP - bit_code];
                    aml_pkg::OP_BR_OVF, aml_pkg::OP_BR_NO_OVF:
                        overflow_flag_q <= 1'b0;
                    default: begin
                    end
                endcase
                if (ovf_ev) begin
                    overflow_flag_q <= 1'b1;
                end
            end
        end
    end

    // branch decisions and store data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            branch_valid_q <= 1'b0;
            branch_taken_q <= 1'b0;
            store_valid_q <= 1'b0;
            store_data_q <= '0;
        end else if (ce) begin
            branch_valid_q <= 1'b0;
            branch_taken_q <= 1'b0;
            store_valid_q <= 1'b0;
            if (go) begin
                unique case (instr.op)
                    aml_pkg::OP_BR_OVF: begin
                        branch_valid_q <= 1'b1;
                        branch_taken_q <= overflow_flag_q;
                    end
                    aml_pkg::OP_BR_NO_OVF: begin
                        branch_valid_q <= 1'b1;
                        branch_taken_q <= !overflow_flag_q;
                    end
                    aml_pkg::OP_BR_FLAG_CLEAR: begin
                        branch_valid_q <= 1'b1;
                        branch_taken_q <= !test_control_flag_q;
                    end
                    aml_pkg::OP_BR_FLAG_SET: begin
                        branch_valid_q <= 1'b1;
                        branch_taken_q <= test_control_flag_q;
                    end
                    aml_pkg::OP_STORE_HIGH: begin
                        store_valid_q <= 1'b1;
                        store_data_q <= store_word[AW-1:DW];
                    end
                    aml_pkg::OP_STORE_LOW: begin
                        store_valid_q <= 1'b1;
                        store_data_q <= store_word[DW-1:0];
                    end
                    aml_pkg::OP_PROD_STORE_HIGH: begin
                        store_valid_q <= 1'b1;
                        store_data_q <= prod_sh[AW-1:DW];
                    end
                    aml_pkg::OP_PROD_STORE_LOW: begin
                        store_valid_q <= 1'b1;
                        store_data_q <= prod_sh[DW-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // bus write channels
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= aml_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == aml_pkg::REG_NONE)
                               ? aml_pkg::RESP_SLVERR : aml_pkg::RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read data mux
    always_comb begin
        rd_word = '0;
        unique case (rd_sel)
            aml_pkg::REG_STATUS_ZERO: begin
                rd_word[aml_pkg::Z_SAT_BIT] = saturate_mode_bit_q;
                rd_word[aml_pkg::Z_OVF_BIT] = overflow_flag_q;
            end
            aml_pkg::REG_STATUS_ONE: begin
                rd_word[aml_pkg::O_SEXT_BIT] = sign_ext_mode_bit_q;
                rd_word[aml_pkg::O_TCF_BIT] = test_control_flag_q;
                rd_word[aml_pkg::O_PSH_HI:aml_pkg::O_PSH_LO] =
                    product_shift_field_q;
            end
            aml_pkg::REG_ACC: rd_word = acc_q;
            aml_pkg::REG_PRODUCT: rd_word = product_reg_q;
            aml_pkg::REG_MCAND: rd_word[DW-1:0] = mcand_q;
            default: rd_word = '0;
        endcase
    end

    // bus read channels
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= aml_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (rd_sel == aml_pkg::REG_NONE)
                               ? aml_pkg::RESP_SLVERR : aml_pkg::RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : aml_core

//--- inc/aml_pkg.sv
// constants, types and register map of the accumulator mode logic
package aml_pkg;
    localparam int ACC_W = 32;
    localparam int DATA_W = 16;
    localparam int SHIFT_W = 4;
    localparam int STORE_SH_W = 3;
    localparam int REG_SPAN_BITS = 8;
    // register byte offsets
    localparam logic [7:0] OFF_STATUS_ZERO = 8'h00;
    localparam logic [7:0] OFF_STATUS_ONE = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_PRODUCT = 8'h0c;
    localparam logic [7:0] OFF_MCAND = 8'h10;
    // field positions, shared by bus registers and status loads
    localparam int Z_SAT_BIT = 0;
    localparam int Z_OVF_BIT = 1;
    localparam int O_SEXT_BIT = 0;
    localparam int O_TCF_BIT = 1;
    localparam int O_PSH_LO = 2;
    localparam int O_PSH_HI = 3;
    // reset values
    localparam logic RST_SEXT = 1'b1;
    localparam logic RST_SAT = 1'b0;
    localparam logic [1:0] RST_PSH = 2'h0;
    // saturation limits
    localparam logic [ACC_W-1:0] ACC_MAX = 32'h7fffffff;
    localparam logic [ACC_W-1:0] ACC_MIN = 32'h80000000;
    // product shift amounts and bit-code top
    localparam int PSH_L1 = 1;
    localparam int PSH_L4 = 4;
    localparam int PSH_R6 = 6;
    localparam logic [SHIFT_W-1:0] BIT_CODE_TOP = 4'hf;
    localparam logic [STORE_SH_W-1:0] EARLY_SH_A = 3'h1;
    localparam logic [STORE_SH_W-1:0] EARLY_SH_B = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PSH_NONE = 2'h0,
        PSH_LEFT1 = 2'h1,
        PSH_LEFT4 = 2'h2,
        PSH_RIGHT6 = 2'h3
    } aml_psh_e;

    typedef enum logic [4:0] {
        OP_ACC_LOAD, OP_ACC_LOAD_VAR, OP_ADD, OP_ADD_VAR, OP_SUB,
        OP_SUB_VAR, OP_PROD_LOAD, OP_PROD_ADD, OP_PROD_SUB,
        OP_MCAND_LOAD, OP_MULT, OP_MULT_ACC, OP_SQUARE_ACC, OP_ACC_SHL,
        OP_ACC_SHR, OP_STORE_HIGH, OP_STORE_LOW, OP_PROD_STORE_HIGH,
        OP_PROD_STORE_LOW, OP_BIT_TEST, OP_BIT_TEST_VAR,
        OP_BR_FLAG_CLEAR, OP_BR_FLAG_SET, OP_BR_OVF, OP_BR_NO_OVF,
        OP_SET_SIGN_EXT, OP_CLR_SIGN_EXT, OP_SET_SAT, OP_CLR_SAT,
        OP_SET_PROD_SHIFT, OP_LOAD_STATUS, OP_LOAD_STATUS_ONE
    } aml_op_e;

    typedef enum logic [2:0] {
        REG_NONE, REG_STATUS_ZERO, REG_STATUS_ONE, REG_ACC, REG_PRODUCT,
        REG_MCAND
    } aml_reg_e;

    typedef struct packed {
        logic valid;
        aml_op_e op;
        logic [SHIFT_W-1:0] arg;
        logic [DATA_W-1:0] data;
    } aml_instr_s;

    typedef struct packed {
        logic [ACC_W-1:0] val;
        logic ovf;
    } aml_sum_s;
endpackage : aml_pkg

//--- tb/aml_core_asserts.sv
// port checker of the accumulator mode logic
module aml_core_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input aml_pkg::aml_instr_s instr,
    input wire logic [aml_pkg::ACC_W-1:0] acc_q,
    input wire logic [aml_pkg::ACC_W-1:0] product_reg_q,
    input wire logic branch_valid_q,
    input wire logic branch_taken_q,
    input wire logic sign_ext_mode_bit_q,
    input wire logic saturate_mode_bit_q,
    input wire logic overflow_flag_q,
    input wire logic test_control_flag_q,
    input wire logic [1:0] product_shift_field_q,
    input wire logic s_axi_awready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic go;
    assign go = ce && instr.valid;
    AST_BR_OVF: assert property (go && instr.op == aml_pkg::OP_BR_OVF |=>
        branch_valid_q && branch_taken_q == $past(overflow_flag_q))
        else $error("overflow branch wrong");
    AST_OVF_CLR: assert property (go && instr.op inside
        {aml_pkg::OP_BR_OVF, aml_pkg::OP_BR_NO_OVF} |=> !overflow_flag_q)
        else $error("overflow flag not cleared by branch");
    AST_OVF_HOLD: assert property (
        overflow_flag_q && s_axi_awready &&
        !(go && instr.op inside {aml_pkg::OP_BR_OVF,
        aml_pkg::OP_BR_NO_OVF, aml_pkg::OP_LOAD_STATUS}) |=> overflow_flag_q)
        else $error("overflow flag lost");
    AST_SEXT: assert property (go && instr.op inside
        {aml_pkg::OP_SET_SIGN_EXT, aml_pkg::OP_CLR_SIGN_EXT} |=>
        sign_ext_mode_bit_q == $past(instr.op == aml_pkg::OP_SET_SIGN_EXT))
        else $error("sign extension bit wrong");
    AST_SAT_MODE: assert property (go && instr.op inside
        {aml_pkg::OP_SET_SAT, aml_pkg::OP_CLR_SAT} |=>
        saturate_mode_bit_q == $past(instr.op == aml_pkg::OP_SET_SAT))
        else $error("saturate bit wrong");
    AST_SAT_POS: assert property (go && instr.op == aml_pkg::OP_ADD &&
        saturate_mode_bit_q && !instr.data[15] && !acc_q[31] |=> !acc_q[31])
        else $error("positive sum wrapped under saturation");
    AST_PSH_R6: assert property (go && instr.op == aml_pkg::OP_PROD_LOAD &&
        product_shift_field_q == 2'h3 |=> acc_q ==
        {{6{$past(product_reg_q[31])}}, $past(product_reg_q[31:6])})
        else $error("product right shift wrong");
    AST_BIT: assert property (go && instr.op == aml_pkg::OP_BIT_TEST |=>
        test_control_flag_q == $past(instr.data[4'hf - instr.arg]))
        else $error("bit test wrong");
    AST_SHL: assert property (go && instr.op == aml_pkg::OP_ACC_SHL |=>
        acc_q == {$past(acc_q[30:0]), 1'b0}) else $error("left shift wrong");
    AST_BR_TC: assert property (go && instr.op inside
        {aml_pkg::OP_BR_FLAG_SET, aml_pkg::OP_BR_FLAG_CLEAR} |=>
        branch_valid_q && branch_taken_q == ($past(test_control_flag_q) ==
        $past(instr.op == aml_pkg::OP_BR_FLAG_SET)))
        else $error("test flag branch wrong");
    cover property (saturate_mode_bit_q && overflow_flag_q);
    cover property (branch_valid_q && branch_taken_q);
    cover property (product_shift_field_q == 2'h3);
endmodule : aml_core_asserts

bind aml_core aml_core_asserts u_asserts (.*);

//--- tb/aml_core_test.sv
// self-checking bench of the accumulator mode logic
module aml_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst = 1, ce = 1, store_valid_q, branch_valid_q;
    logic branch_taken_q, sign_ext_mode_bit_q, saturate_mode_bit_q;
    logic overflow_flag_q, test_control_flag_q, s_axi_awvalid = 0;
    logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] product_shift_field_q, s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [15:0] store_data_q;
    logic [31:0] acc_q, product_reg_q, s_axi_wdata = 0, s_axi_rdata, d;
    logic [31:0] exp_ps [4] = '{32'hfffff400, 32'hffffe800, 32'hffff4000,
        32'hffffffd0};
    aml_pkg::aml_instr_s instr = '0;
    int errors = 0, n_checks = 0;
    aml_core uut (.*);
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    task summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task run(aml_pkg::aml_op_e op, logic [3:0] a, logic [15:0] dt);
        @(posedge sys_clk);
        instr <= '{1'b1, op, a, dt};
        @(posedge sys_clk);
        instr.valid <= 1'b0;
        @(negedge sys_clk);
    endtask : run
    task wr(logic [7:0] a, logic [31:0] dt);
        int i;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 20) begin
            errors++;
            summarize();
        end
    endtask : wr
    task rd(logic [7:0] a);
        int i;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 20) begin
            errors++;
            summarize();
        end
    endtask : rd
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h04);
        chk("status one", 32'h1, d);
        wr(8'h00, 32'h1);
        chk("bresp", aml_pkg::RESP_OKAY, r);
        chk("sat bus", 1, saturate_mode_bit_q);
        run(aml_pkg::OP_CLR_SAT, 0, 0);
        chk("sat clr", 0, saturate_mode_bit_q);
        run(aml_pkg::OP_CLR_SIGN_EXT, 0, 0);
        run(aml_pkg::OP_ACC_LOAD, 0, 16'h8000);
        chk("load nosx", 32'h8000, acc_q);
        run(aml_pkg::OP_ACC_SHR, 0, 0);
        chk("shr logic", 32'h4000, acc_q);
        run(aml_pkg::OP_SET_SIGN_EXT, 0, 0);
        run(aml_pkg::OP_ACC_LOAD, 4'h1, 16'h8000);
        chk("load sx", 32'hffff0000, acc_q);
        run(aml_pkg::OP_ACC_SHR, 0, 0);
        chk("shr arith", 32'hffff8000, acc_q);
        run(aml_pkg::OP_ACC_SHL, 0, 0);
        chk("shl", 32'hffff0000, acc_q);
        run(aml_pkg::OP_MCAND_LOAD, 0, 16'hfff4);
        run(aml_pkg::OP_ADD_VAR, 0, 16'h0003);
        chk("add var", 32'hffff0030, acc_q);
        run(aml_pkg::OP_MULT, 0, 16'h0100);
        chk("product", 32'hfffff400, product_reg_q);
        for (int k = 0; k < 4; k++) begin
            run(aml_pkg::OP_SET_PROD_SHIFT, k[3:0], 0);
            chk("field", k, product_shift_field_q);
            run(aml_pkg::OP_PROD_LOAD, 0, 0);
            chk("prod shift", exp_ps[k], acc_q);
        end
        run(aml_pkg::OP_MULT_ACC, 0, 16'h0100);
        chk("mac shift", 32'hffffffa0, acc_q);
        run(aml_pkg::OP_BIT_TEST, 4'hb, 16'h0010);
        chk("bit", 1, test_control_flag_q);
        run(aml_pkg::OP_BR_FLAG_SET, 0, 0);
        chk("br set", 1, branch_taken_q);
        run(aml_pkg::OP_BIT_TEST_VAR, 0, 16'h0010);
        chk("bit var", 0, test_control_flag_q);
        run(aml_pkg::OP_BR_FLAG_CLEAR, 0, 0);
        chk("br clr", 1, branch_taken_q);
        run(aml_pkg::OP_SET_SAT, 0, 0);
        run(aml_pkg::OP_ACC_LOAD, 4'hf, 16'h7fff);
        run(aml_pkg::OP_ADD, 4'hf, 16'h7fff);
        chk("no ovf", 0, overflow_flag_q);
        run(aml_pkg::OP_ADD, 4'hf, 16'h7fff);
        chk("sat max", 32'h7fffffff, acc_q);
        run(aml_pkg::OP_ACC_LOAD, 0, 0);
        chk("ovf sticky", 1, overflow_flag_q);
        run(aml_pkg::OP_BR_NO_OVF, 0, 0);
        chk("bnv", 0, branch_taken_q);
        chk("ovf clr", 0, overflow_flag_q);
        run(aml_pkg::OP_ACC_LOAD, 4'hf, 16'h8000);
        run(aml_pkg::OP_SUB, 4'hf, 16'h7fff);
        run(aml_pkg::OP_SUB, 4'hf, 16'h7fff);
        chk("sat min", 32'h80000000, acc_q);
        run(aml_pkg::OP_BR_OVF, 0, 0);
        chk("bv", 1, branch_taken_q);
        run(aml_pkg::OP_ACC_LOAD, 0, 16'h0003);
        run(aml_pkg::OP_STORE_LOW, 4'h7, 0);
        chk("store", 32'h1_0180, {store_valid_q, store_data_q});
        run(aml_pkg::OP_LOAD_STATUS_ONE, 0, 16'h000d);
        chk("load_status_one_instr", 32'h3, product_shift_field_q);
        run(aml_pkg::OP_PROD_STORE_LOW, 0, 0);
        chk("pstore", 32'h1_ffd0, {store_valid_q, store_data_q});
        rd(8'h20);
        chk("unmapped", {30'h0, aml_pkg::RESP_SLVERR}, {d[29:0], r});
        summarize();
    end
endmodule : aml_core_test
